// ### src/vcrcr_defs.svh
`ifndef VCRCR_DEFS_SVH
`define VCRCR_DEFS_SVH
// byte addresses on the register bus
`define VCRCR_CAP_ADDR 12'h210
`define VCRCR_CTL_ADDR 12'h214
`define VCRCR_STS_ADDR 12'h218
`define VCRCR_TBL_ADDR 12'h220
// capability fields
`define VCRCR_CAP_APS_BIT 14
`define VCRCR_CAP_RJS_BIT 15
`define VCRCR_MAX_TIME_SLOTS_VALUE 7'h00
`define VCRCR_OFF_UP 8'h02
`define VCRCR_OFF_DOWN 8'h00
`define VCRCR_ARBCAP_UP 8'h03
`define VCRCR_ARBCAP_DOWN 8'h01
// control fields
`define VCRCR_TCMAP_RESET 8'hFF
`define VCRCR_LOAD_BIT 16
`define VCRCR_SEL_LSB 17
`define VCRCR_SEL_RESET 3'h0
`define VCRCR_VCEN_BIT 31
// status fields
`define VCRCR_STS_BIT 16
// arbitration table entry reset value (eight 4-bit phases)
`define VCRCR_TBL_RESET 32'h00006442
// cycles taken to copy the table into the arbiter
`define VCRCR_LOAD_CYCLES 4'h8
`endif

// ### src/vcrcr_pkg.sv
`default_nettype none
package vcrcr_pkg;
  typedef enum logic [1:0] {
    VCRCR_IDLE = 2'b00,
    VCRCR_COPY = 2'b01,
    VCRCR_SWAP = 2'b10
  } vcrcr_load_type;
endpackage
`default_nettype wire

// ### src/vcrcr_regs.sv
// Contract
// - Advanced packet switching capability bit reads zero; writes ignored.
// - Reject-snoop capability bit reads zero, read-only.
// - Maximum time slots field is zero, read-only.
// - Arbitration table offset is 0x2 upstream, 0x0 downstream, 16-byte units.
// - Each traffic class map bit set maps that class to channel 0.
// - Map bit zero read-only, bits one to seven writable, reset 0xFF.
// - Writing one to load trigger copies the table into the arbiter.
// - Writing zero to load trigger has no effect.
// - Load trigger always reads zero.
// - Load trigger acts only on upstream port; ignored downstream.
// - Load leaves the arbiter's table unchanged while fixed round robin is selected; status still clears.
// - Table status sets on table write, clears when load finishes.
// - Writable arbitration select picks scheme among capability bits set.
// - Upstream advertises fixed RR and 32-phase WRR; downstream fixed RR.
`include "vcrcr_defs.svh"
`default_nettype none
module vcrcr_regs #(
  parameter bit UPSTREAM = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic [7:0] traffic_class_map, // classes routed to channel 0
  output logic [2:0] arb_scheme_select, // selected arbitration scheme
  output logic [31:0] arb_table_active, // table the arbiter uses
  output logic table_status // table not yet latched
);

  ////////////////////////////////////////////////////////////////////////////
  // the two port builds differ in what they advertise, where the table sits and whether table writes and loads act;
  // downstream has no table, so its offset is zero
  localparam logic [7:0] ARBCAP = UPSTREAM ? `VCRCR_ARBCAP_UP : `VCRCR_ARBCAP_DOWN;
  localparam logic [7:0] TBLOFF = UPSTREAM ? `VCRCR_OFF_UP : `VCRCR_OFF_DOWN;

  // byte lanes picked by sel take the new bytes; the others keep the old ones
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction

  // a scheme value is legal only if its capability bit is set
  function automatic logic sel_legal(input logic [2:0] v);
    return ARBCAP[v];
  endfunction

  // one register decode, shared by the read mux and the write paths
  function automatic logic addr_is(
    input logic [ADDR_W-1:0] a,
    input logic [11:0] target
  );
    return a == ADDR_W'(target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus side
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] lane_mask;
  logic hit_cap;
  logic hit_ctl;
  logic hit_sts;
  logic hit_tbl;

  // assembled register words
  logic [31:0] cap_word;
  logic [31:0] ctl_word;

  // load sequencer state
  logic [31:0] arb_table_shadow;
  logic [3:0] load_count;
  vcrcr_pkg::vcrcr_load_type load_state;
  logic trig;
  logic tbl_wr;

  // next values
  logic [31:0] next_dat;
  logic next_ack;
  logic [7:0] next_map;
  logic [2:0] next_sel;
  logic [31:0] next_shadow;
  logic [31:0] next_active;
  logic next_status;
  logic [3:0] next_count;
  vcrcr_pkg::vcrcr_load_type next_state;

  // ack low in the request test keeps a held strobe from starting a second access
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign wmask = lane_mask;

  assign hit_cap = addr_is(wb_adr_i, `VCRCR_CAP_ADDR);
  assign hit_ctl = addr_is(wb_adr_i, `VCRCR_CTL_ADDR);
  assign hit_sts = addr_is(wb_adr_i, `VCRCR_STS_ADDR);
  assign hit_tbl = addr_is(wb_adr_i, `VCRCR_TBL_ADDR);

  // each lane of the mask follows its own select bit
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_mask[8*g+:8] = {8{wb_sel_i[g]}};
  end

  always_comb begin
    cap_word = 32'h00000000;
    cap_word[7:0] = ARBCAP;
    // all constants: writes to the capability word are acked and dropped
    // no advanced switching, and a switch port never rejects snoops
    cap_word[`VCRCR_CAP_APS_BIT] = 1'b0;
    cap_word[`VCRCR_CAP_RJS_BIT] = 1'b0;
    // time slots mean nothing without time-based weighted round robin
    cap_word[22:16] = `VCRCR_MAX_TIME_SLOTS_VALUE;
    cap_word[31:24] = TBLOFF;
  end

  always_comb begin
    ctl_word = 32'h00000000;
    ctl_word[7:0] = traffic_class_map;
    ctl_word[`VCRCR_LOAD_BIT] = 1'b0;
    ctl_word[`VCRCR_SEL_LSB+:3] = arb_scheme_select;
    // only one channel exists, so its enable is fixed on
    ctl_word[`VCRCR_VCEN_BIT] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one-cycle ack, unmapped reads return zero, writes dropped
  // read data is zero outside the ack cycle so a wired-or bus can share it
  always_comb begin
    next_ack = req;
    next_dat = 32'h00000000;
    if (req && !wb_we_i) begin
      case (1'b1)
        hit_cap: begin
          next_dat = cap_word;
        end
        hit_ctl: begin
          next_dat = ctl_word;
        end
        hit_sts: begin
          next_dat = {15'h0000, table_status, 16'h0000};
        end
        hit_tbl: begin
          next_dat = arb_table_shadow;
        end
        default: begin
          next_dat = 32'h00000000;
        end
      endcase
    end
  end

  // registering ack costs a cycle per access but keeps every output on a flop;
  // the slave therefore answers exactly one edge after it takes a request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields: traffic class map
  always_comb begin
    next_map = traffic_class_map;
    // class 0 always rides channel 0, so bit zero is forced back on
    if (wr && hit_ctl && wb_sel_i[0]) begin
      next_map = {wb_dat_i[7:1], 1'b1};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      traffic_class_map <= `VCRCR_TCMAP_RESET;
    end else begin
      traffic_class_map <= next_map;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields: arbitration scheme select
  always_comb begin
    next_sel = arb_scheme_select;
    // illegal scheme values are dropped so the field always names a capability
    if (wr && hit_ctl && wb_sel_i[2] && sel_legal(wb_dat_i[`VCRCR_SEL_LSB+:3])) begin
      next_sel = wb_dat_i[`VCRCR_SEL_LSB+:3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arb_scheme_select <= `VCRCR_SEL_RESET;
    end else begin
      arb_scheme_select <= next_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software copy of the table; the arbiter sees it only after a load
  // downstream ports have no table, so writes there never reach it
  always_comb begin
    next_shadow = arb_table_shadow;
    if (tbl_wr) begin
      next_shadow = lane_merge(arb_table_shadow, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arb_table_shadow <= `VCRCR_TBL_RESET;
    end else begin
      arb_table_shadow <= next_shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table load sequencer
  // a load spends a fixed count of cycles in COPY and swaps in SWAP; the active
  // table is written only in SWAP, so the arbiter never sees a half-copied table
  // a trigger that lands while a load runs is dropped rather than queued, so
  // software waits for the status to fall before asking again
  // with fixed round robin selected a load still clears the status but leaves
  // the arbiter's table alone
  assign tbl_wr = wr && hit_tbl && UPSTREAM;
  // only a written one on the upstream port starts a load
  assign trig = wr && hit_ctl && wb_sel_i[2]
                && wb_dat_i[`VCRCR_LOAD_BIT] && UPSTREAM;

  always_comb begin
    next_active = arb_table_active;
    next_status = table_status;
    next_count = load_count;
    next_state = load_state;
    case (load_state)
      vcrcr_pkg::VCRCR_IDLE: begin
        // a written zero never raises trig, so it changes nothing here
        if (trig) begin
          next_state = vcrcr_pkg::VCRCR_COPY;
          next_count = `VCRCR_LOAD_CYCLES;
        end
      end
      vcrcr_pkg::VCRCR_COPY: begin
        // old table stays in use while the copy runs; one left means done
        next_count = load_count - 4'h1;
        if (load_count == 4'h1) begin
          next_state = vcrcr_pkg::VCRCR_SWAP;
        end
      end
      vcrcr_pkg::VCRCR_SWAP: begin
        // fixed round robin never reads the table, so the arbiter keeps its view
        if (arb_scheme_select != 3'h0) begin
          next_active = arb_table_shadow;
        end
        next_status = 1'b0;
        next_state = vcrcr_pkg::VCRCR_IDLE;
      end
      // an unused code falls back to idle and abandons the load
      default: next_state = vcrcr_pkg::VCRCR_IDLE;
    endcase
    // a table write in the finishing cycle leaves the status set
    // any written lane counts, whatever the data, so a zero entry still marks it stale
    if (tbl_wr && |wmask) begin
      next_status = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // the active table restarts from the same image as the shadow
      arb_table_active <= `VCRCR_TBL_RESET;
      table_status <= 1'b0;
      load_count <= 4'h0;
      load_state <= vcrcr_pkg::VCRCR_IDLE;
    end else begin
      arb_table_active <= next_active;
      table_status <= next_status;
      load_count <= next_count;
      load_state <= next_state;
    end
  end

endmodule
`default_nettype wire

// ### bench/vcrcr_chk.sv
`include "vcrcr_defs.svh"
`default_nettype none
module vcrcr_chk #(
  parameter bit UPSTREAM = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [ADDR_W-1:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic [7:0] traffic_class_map, // map
  input wire logic [2:0] arb_scheme_select, // select
  input wire logic [31:0] arb_table_active, // table
  input wire logic table_status // status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // status rises at the edge after the write is taken; the check also accepts a cause two edges back
  wire logic tbl_wr = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == `VCRCR_TBL_ADDR);
  wire logic rd_ack = wb_ack_o & ~wb_we_i;
  //////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("data outside ack");
  a_cap_high: assert property (rd_ack && wb_adr_i == `VCRCR_CAP_ADDR |->
    wb_dat_o[31:14] == {(UPSTREAM ? `VCRCR_OFF_UP : `VCRCR_OFF_DOWN), 10'h000})
    else $error("capability high bits wrong");
  a_trig_zero: assert property (rd_ack && wb_adr_i == `VCRCR_CTL_ADDR |-> !wb_dat_o[16])
    else $error("trigger reads one");
  a_map_bit0: assert property (traffic_class_map[0] == 1'b1)
    else $error("map bit zero clear");
  a_sel_legal: assert property (arb_scheme_select <= (UPSTREAM ? 3'h1 : 3'h0))
    else $error("select illegal");
  a_status_cause: assert property ($rose(table_status) |-> $past(tbl_wr) || $past(tbl_wr, 2))
    else $error("status set without table write");
  a_down_quiet: assert property (!UPSTREAM |-> !table_status)
    else $error("downstream status set");
endmodule
bind vcrcr_regs vcrcr_chk #(.UPSTREAM(UPSTREAM), .ADDR_W(ADDR_W)) i_vcrcr_chk (.*);
`default_nettype wire

// ### bench/testbench.sv
`include "vcrcr_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, r, tbl;
  logic [31:0] rdat [2], act [2], rd [2];
  logic [7:0] map [2];
  logic [2:0] asel [2], s_up;
  logic ack [2], sts [2];
  int error_cnt = 0, checked = 0, seed = 48;
  // index 0 is the upstream port, index 1 a downstream one
  for (genvar g = 0; g < 2; g++) begin : g_port
    vcrcr_regs #(.UPSTREAM(g == 0)) i_vcrcr_regs (.*, .wb_dat_o(rdat[g]), .wb_ack_o(ack[g]),
      .traffic_class_map(map[g]), .arb_scheme_select(asel[g]), .arb_table_active(act[g]),
      .table_status(sts[g]));
  end
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the request stands until the rising edge that samples ack high; read data is
  // taken and the request dropped at that same edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack[0] !== 1'b1 && n < 20);
    if (n == 20) error_cnt++;
    rd = rdat;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] eu, input logic [31:0] ed);
    wb(1'b0, a, 32'h00000000, 4'h0);
    cmp(rd[0], eu);
    cmp(rd[1], ed);
  endtask
  function automatic logic [31:0] ctl_exp(input logic [7:0] m, input logic [2:0] s);
    return {1'b1, 11'h000, s, 1'b0, 8'h00, m | 8'h01};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdchk(12'h210, 32'h02000003, 32'h00000001);
    rdchk(12'h214, 32'h800000FF, 32'h800000FF);
    s_up = 3'h0;
    for (int i = 0; i < 14; i++) begin
      r = (i == 0) ? 32'h0000FF00 : $random(seed);
      wb(1'b1, 12'h214, r, 4'h5);
      if (r[19:17] <= 3'h1) s_up = r[19:17];
      rdchk(12'h214, ctl_exp(r[7:0], s_up), ctl_exp(r[7:0], 3'h0));
      cmp(map[1], r[7:0] | 8'h01);
      cmp({29'h0, asel[0]}, {29'h0, s_up});
      cmp({29'h0, asel[1]}, 32'h00000000);
    end
    repeat (12) @(posedge clk_sys);
    wb(1'b1, 12'h214, 32'h00020000, 4'h4);
    tbl = $random(seed);
    wb(1'b1, 12'h220, tbl, 4'hF);
    rdchk(12'h218, 32'h00010000, 32'h00000000);
    wb(1'b1, 12'h214, 32'h00020000, 4'h4);
    repeat (12) @(posedge clk_sys);
    cmp(sts[0], 32'h1);
    cmp(act[0], `VCRCR_TBL_RESET);
    wb(1'b1, 12'h214, 32'h00030000, 4'h4);
    repeat (12) @(posedge clk_sys);
    cmp(act[0], tbl);
    cmp(act[1], `VCRCR_TBL_RESET);
    rdchk(12'h218, 32'h00000000, 32'h00000000);
    wb(1'b1, 12'h214, 32'h00000000, 4'h4);
    wb(1'b1, 12'h220, ~tbl, 4'hF);
    wb(1'b1, 12'h214, 32'h00010000, 4'h4);
    repeat (12) @(posedge clk_sys);
    cmp(act[0], tbl);
    cmp(sts[0], 32'h0);
    wb(1'b1, 12'h3FC, 32'hFFFFFFFF, 4'hF);
    rdchk(12'h3FC, 32'h00000000, 32'h00000000);
    conclude();
  end
endmodule
`default_nettype wire
